// ---- hw/serial_defs.vh ----
// Constants for the two-channel serial controller: port addresses,
// command codes, register indices, control field bit positions and vector codes.
// Assumes a byte-wide host port with full 24-bit byte addresses.
`ifndef SERIAL_DEFS_VH
`define SERIAL_DEFS_VH

// ==========================================================
// Host port addresses
`define CH0_DATA_ADDR 24'hc21001
`define CH0_CTRL_ADDR 24'hc21005
`define CH_STRIDE 24'h000002

// ==========================================================
// Control register 0 command codes, bits 5-3
`define CMD_NULL 3'h0
`define CMD_RST_EXT 3'h2
`define CMD_CHAN_RST 3'h3
`define CMD_RST_TXIP 3'h5
`define CMD_ERR_RST 3'h6

// ==========================================================
// Register indices and field positions
`define WR_INT_CTRL 3'h1
`define WR_VECTOR 3'h2
`define WR_PARITY 3'h4
`define SAV_BIT 2
`define TXIE_BIT 1
`define EXTIE_BIT 0
`define PAR_EN_BIT 0
`define RR_STATUS0 3'h0
`define RR_STATUS1 3'h1
`define RR_VECTOR 3'h2

// ==========================================================
// Vector source codes (channel 0 adds bit 2)
`define SRC_TX 2'h0
`define SRC_EXT 2'h1
`define SRC_RX 2'h2
`define SRC_SP 2'h3
`define RX_DEPTH 2'h3
`define RXM_NO_PARITY 2'h3

`endif

// ---- hw/serial_ctrl_vector_status.v ----
// Two-channel serial controller core: control/data ports, receive buffer,
// latched error and external status, interrupt vector generation.
// Character assembly happens outside on mclk; line status pins are async.
`timescale 1ns/1ps
`include "serial_defs.vh"

module serial_ctrl_vector_status (
  input wire mclk,
  input wire rst_n,
  input wire [23:0] host_addr,
  input wire host_wr,
  input wire host_rd,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata,
  input wire [1:0] rx_valid,
  input wire [7:0] rx_data0,
  input wire [7:0] rx_data1,
  input wire [1:0] rx_parity_err,
  input wire [1:0] rx_framing_err,
  input wire [1:0] line_break,
  input wire [1:0] cts,
  input wire [1:0] dcd,
  output wire [1:0] tx_valid,
  output reg [7:0] tx_data0,
  output reg [7:0] tx_data1,
  input wire [1:0] tx_ready,
  output reg int_req,
  output reg [7:0] int_vector
);

  // ==========================================================
  // Address decode
  // Returns {hit, channel, is_control}
  function [2:0] port_sel;
    input [23:0] a;
    begin
      if (a == `CH0_DATA_ADDR)
        port_sel = 3'h4;
      else if (a == `CH0_CTRL_ADDR)
        port_sel = 3'h5;
      else if (a == `CH0_DATA_ADDR + `CH_STRIDE)
        port_sel = 3'h6;
      else if (a == `CH0_CTRL_ADDR + `CH_STRIDE)
        port_sel = 3'h7;
      else
        port_sel = 3'h0;
    end
  endfunction

  wire [2:0] sel = port_sel(host_addr);
  reg [1:0] ctl_wr, ctl_rd, dat_wr, dat_rd;
  // Each process keeps its own loop index, so no variable has two drivers
  integer c, k, m, n;

  // Strobes per channel
  always @* begin
    for (m = 0; m < 2; m = m + 1) begin
      ctl_wr[m] = host_wr && sel[2] && (sel[1] == m) && sel[0];
      ctl_rd[m] = host_rd && sel[2] && (sel[1] == m) && sel[0];
      dat_wr[m] = host_wr && sel[2] && (sel[1] == m) && !sel[0];
      dat_rd[m] = host_rd && sel[2] && (sel[1] == m) && !sel[0];
    end
  end

  // ==========================================================
  // State
  reg [7:0] wr_reg [0:15];  // Write registers, index ch*8 + pointer
  reg [7:0] rx_mem [0:5];   // Receive buffer, ch*3 + slot, slot 0 oldest
  reg [2:0] ptr_reg [0:1];
  reg [1:0] cnt_reg [0:1];
  reg [2:0] err_reg [0:1];  // {framing, overrun, parity}
  reg [2:0] snap_reg [0:1]; // {break, cts, dcd}
  reg [1:0] chg_reg, ext_ip_reg, tx_ip_reg, hold_full_reg;
  reg [5:0] sync1_reg, sync2_reg; // First stage feeds only the second

  // Line status pins pass two flops
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {line_break, cts, dcd};
      sync2_reg <= sync1_reg;
    end
  end

  reg [2:0] live [0:1];
  reg [1:0] rx_mode;
  reg [2:0] cmd;
  reg [1:0] sp_ip, rx_ip;
  reg [7:0] rx_in [0:1];

  // Per-channel decode of commands and interrupt sources
  always @* begin
    rx_in[0] = rx_data0;
    rx_in[1] = rx_data1;
    for (n = 0; n < 2; n = n + 1) begin
      live[n] = {sync2_reg[4+n], sync2_reg[2+n], sync2_reg[n]};
      rx_mode = wr_reg[n*8+1][4:3];
      // Special receive whenever any receive interrupt form is on
      sp_ip[n] = (rx_mode != 2'h0) && (err_reg[n][2] || err_reg[n][1] ||
        (err_reg[n][0] && rx_mode != `RXM_NO_PARITY));
      rx_ip[n] = (rx_mode != 2'h0) && (cnt_reg[n] != 2'h0);
    end
    cmd = host_wdata[5:3];
  end

  // ==========================================================
  // Channel registers, buffer, status latches
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (k = 0; k < 16; k = k + 1)
        wr_reg[k] <= 8'h00;
      for (k = 0; k < 6; k = k + 1)
        rx_mem[k] <= 8'h00;
      for (k = 0; k < 2; k = k + 1) begin
        ptr_reg[k] <= 3'h0;
        cnt_reg[k] <= 2'h0;
        err_reg[k] <= 3'h0;
        snap_reg[k] <= 3'h0;
      end
      chg_reg <= 2'h0;
      ext_ip_reg <= 2'h0;
      tx_ip_reg <= 2'h0;
      hold_full_reg <= 2'h0;
      tx_data0 <= 8'h00;
      tx_data1 <= 8'h00;
    end else begin
      for (c = 0; c < 2; c = c + 1) begin
        // Pointer walks back to zero after any pointed access
        if (ctl_wr[c] || ctl_rd[c]) begin
          if (ctl_wr[c] && ptr_reg[c] == 3'h0)
            ptr_reg[c] <= host_wdata[2:0];
          else
            ptr_reg[c] <= 3'h0;
        end
        if (ctl_wr[c] && ptr_reg[c] != 3'h0)
          wr_reg[c*8+ptr_reg[c]] <= host_wdata;

        // Receive buffer: pop on data read, push from assembler
        if (dat_rd[c] && cnt_reg[c] != 2'h0) begin
          rx_mem[c*3] <= rx_mem[c*3+1];
          rx_mem[c*3+1] <= rx_mem[c*3+2];
        end
        if (rx_valid[c] && cnt_reg[c] != `RX_DEPTH)
          rx_mem[c*3+cnt_reg[c]-(dat_rd[c] && cnt_reg[c] != 2'h0)] <=
            rx_in[c];
        else if (rx_valid[c] && dat_rd[c])
          rx_mem[c*3+2] <= rx_in[c];
        cnt_reg[c] <= cnt_reg[c]
          + {1'b0, rx_valid[c] && (cnt_reg[c] != `RX_DEPTH || dat_rd[c])}
          - {1'b0, dat_rd[c] && cnt_reg[c] != 2'h0};

        // New errors win over an error reset in the same cycle
        err_reg[c] <= (err_reg[c] & {3{!(ctl_wr[c] && ptr_reg[c] == 3'h0
            && cmd == `CMD_ERR_RST)}})
          | {rx_valid[c] && rx_framing_err[c],
             rx_valid[c] && cnt_reg[c] == `RX_DEPTH && !dat_rd[c],
             rx_valid[c] && rx_parity_err[c]
               && wr_reg[c*8+`WR_PARITY][`PAR_EN_BIT]};

        // External status: follow live lines until a change freezes them
        if (ctl_wr[c] && ptr_reg[c] == 3'h0 && cmd == `CMD_RST_EXT) begin
          snap_reg[c] <= live[c];
          chg_reg[c] <= 1'b0;
          ext_ip_reg[c] <= 1'b0;
        end else if (!chg_reg[c] && live[c] != snap_reg[c]) begin
          snap_reg[c] <= live[c];
          chg_reg[c] <= 1'b1;
          ext_ip_reg[c] <= wr_reg[c*8+1][`EXTIE_BIT];
        end

        // Transmit holding byte; going empty raises transmit interrupt
        if (dat_wr[c]) begin
          hold_full_reg[c] <= 1'b1;
          if (c == 0)
            tx_data0 <= host_wdata;
          else
            tx_data1 <= host_wdata;
        end else if (hold_full_reg[c] && tx_ready[c])
          hold_full_reg[c] <= 1'b0;
        if (hold_full_reg[c] && tx_ready[c] && !dat_wr[c])
          tx_ip_reg[c] <= tx_ip_reg[c] | wr_reg[c*8+1][`TXIE_BIT];
        else if (dat_wr[c] || (ctl_wr[c] && ptr_reg[c] == 3'h0
            && cmd == `CMD_RST_TXIP))
          tx_ip_reg[c] <= 1'b0;

        // Channel reset clears write registers (not channel 1's vector), count, errors, transmit and external pending; latest write wins
        if (ctl_wr[c] && ptr_reg[c] == 3'h0 && cmd == `CMD_CHAN_RST) begin
          for (k = 1; k < 8; k = k + 1)
            if (c == 0 || k != `WR_VECTOR)
              wr_reg[c*8+k] <= 8'h00;
          cnt_reg[c] <= 2'h0;
          err_reg[c] <= 3'h0;
          tx_ip_reg[c] <= 1'b0;
          ext_ip_reg[c] <= 1'b0;
          hold_full_reg[c] <= 1'b0;
        end
      end
    end
  end

  assign tx_valid = hold_full_reg;

  // ==========================================================
  // Vector selection; base and mode live in channel 1 registers
  reg [7:0] vec_next;
  reg pend;
  reg [2:0] code;
  always @* begin
    pend = 1'b1;
    // Channel 0 first, then special, receive, transmit, external
    if (sp_ip[0])
      code = {1'b1, `SRC_SP};
    else if (rx_ip[0])
      code = {1'b1, `SRC_RX};
    else if (tx_ip_reg[0])
      code = {1'b1, `SRC_TX};
    else if (ext_ip_reg[0])
      code = {1'b1, `SRC_EXT};
    else if (sp_ip[1])
      code = {1'b0, `SRC_SP};
    else if (rx_ip[1])
      code = {1'b0, `SRC_RX};
    else if (tx_ip_reg[1])
      code = {1'b0, `SRC_TX};
    else if (ext_ip_reg[1]) begin
      code = {1'b0, `SRC_EXT};
    end else begin
      code = 3'h0;
      pend = 1'b0;
    end
    if (wr_reg[8+`WR_INT_CTRL][`SAV_BIT])
      vec_next = {wr_reg[8+`WR_VECTOR][7:4], code,
        wr_reg[8+`WR_VECTOR][0]};
    else
      vec_next = wr_reg[8+`WR_VECTOR];
  end

  // Registered vector and request
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_vector <= 8'h00;
      int_req <= 1'b0;
    end else begin
      int_vector <= vec_next;
      int_req <= pend;
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe; unmapped reads give zero
  reg [7:0] rd_next;
  reg [0:0] chs;
  always @* begin
    chs = sel[1];
    rd_next = 8'h00;
    if (sel[2] && !sel[0])
      rd_next = rx_mem[chs*3];
    else if (sel[2]) begin
      case (ptr_reg[chs])
        `RR_STATUS0: rd_next = {snap_reg[chs][2], 1'b0, snap_reg[chs][1],
          1'b0, snap_reg[chs][0], !hold_full_reg[chs],
          pend && chs == 1'b0, cnt_reg[chs] != 2'h0};
        `RR_STATUS1: rd_next = {1'b0, err_reg[chs], 3'h0,
          !hold_full_reg[chs]};
        `RR_VECTOR: rd_next = (chs == 1'b1) ? vec_next : 8'h00;
        default: rd_next = 8'h00;
      endcase
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      host_rdata <= 8'h00;
    else if (host_rd)
      host_rdata <= rd_next;
  end

endmodule // serial_ctrl_vector_status

// ---- verification/serial_vs_sva.sv ----
// Checker for host, transmit and vector outputs of the serial core.
// Sees only the core's ports; attached by the bind at the foot.
`timescale 1ns/1ps
module serial_vs_sva (
  input wire mclk,
  input wire rst_n,
  input wire [23:0] host_addr,
  input wire host_wr,
  input wire host_rd,
  input wire [7:0] host_wdata,
  input wire [7:0] host_rdata,
  input wire [1:0] tx_valid,
  input wire [7:0] tx_data0,
  input wire [7:0] tx_data1,
  input wire [1:0] tx_ready,
  input wire int_req,
  input wire [7:0] int_vector
);
  // ==========
  // Shared clock, reset silences all
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire mapped;
  assign mapped = host_addr[23:3] == 21'h184200 && host_addr[0];
  sequence s_put0; host_wr && host_addr == 24'hc21001; endsequence
  sequence s_put1; host_wr && host_addr == 24'hc21003; endsequence
  // ==========
  // Transmit holding byte
  a_tx_load0: assert property (s_put0 |=> tx_valid[0] &&
    tx_data0 == $past(host_wdata)) else $error("ch0 byte not loaded");
  a_tx_load1: assert property (s_put1 |=> tx_valid[1] &&
    tx_data1 == $past(host_wdata)) else $error("ch1 byte not loaded");
  a_tx_clear0: assert property (tx_valid[0] && tx_ready[0] &&
    !host_wr |=> !tx_valid[0]) else $error("ch0 byte not released");
  a_tx_hold0: assert property (tx_valid[0] && !tx_ready[0] &&
    !host_wr |=> tx_valid[0] && $stable(tx_data0))
    else $error("ch0 byte dropped");
  a_tx_hold1: assert property (tx_valid[1] && !tx_ready[1] &&
    !host_wr |=> tx_valid[1] && $stable(tx_data1))
    else $error("ch1 byte dropped");
  // ==========
  // Host read data and vector frame
  a_rd_unmapped: assert property (host_rd && !mapped ##1 !host_rd
    |=> host_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!host_rd && !$past(host_rd)
    |=> $stable(host_rdata)) else $error("read data moved");
  a_vec_frame: assert property (int_req && $past(int_req) &&
    !$past(host_wr) && !$past(host_wr, 2) |->
    int_vector[7:4] == $past(int_vector[7:4]) &&
    int_vector[0] == $past(int_vector[0])) else $error("vector frame moved");
endmodule // serial_vs_sva
bind serial_ctrl_vector_status serial_vs_sva chk (.mclk(mclk),
  .rst_n(rst_n), .host_addr(host_addr), .host_wr(host_wr),
  .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
  .tx_valid(tx_valid), .tx_data0(tx_data0), .tx_data1(tx_data1),
  .tx_ready(tx_ready), .int_req(int_req), .int_vector(int_vector));

// ---- verification/serial_line_model.sv ----
// Far-side line model: delivers assembled characters, takes bytes.
// Driven from the bench by calls to send; runs on the core's clock.
`timescale 1ns/1ps
module serial_line_model (
  input wire mclk,
  input wire [1:0] tx_valid,
  input wire [7:0] tx_data0,
  input wire [7:0] tx_data1,
  output reg [1:0] tx_ready,
  output reg [1:0] rx_valid,
  output reg [7:0] rx_data0,
  output reg [7:0] rx_data1,
  output reg [1:0] rx_parity_err,
  output reg [1:0] rx_framing_err
);
  logic [7:0] got[2][$];
  initial begin
    tx_ready = 2'h0;
    rx_valid = 2'h0;
    rx_data0 = 8'h00;
    rx_data1 = 8'h00;
    rx_parity_err = 2'h0;
    rx_framing_err = 2'h0;
  end
  // Random stall, so bytes go out both at once and late
  always @(negedge mclk) tx_ready <= 2'($urandom_range(3));
  // Record every byte taken
  always @(posedge mclk) begin
    for (int i = 0; i < 2; i++)
      if (tx_valid[i] && tx_ready[i])
        got[i].push_back(i ? tx_data1 : tx_data0);
  end
  // ==========
  // One character; released lines show the inverse, not a stale copy
  task automatic send(input int ch, input logic [7:0] d,
                      input logic pe, input logic fe);
    @(negedge mclk);
    rx_parity_err[ch] = pe;
    rx_framing_err[ch] = fe;
    if (ch) rx_data1 = d; else rx_data0 = d;
    rx_valid[ch] = 1'b1;
    @(negedge mclk);
    rx_valid[ch] = 1'b0;
    rx_parity_err[ch] = ~pe;
    rx_framing_err[ch] = ~fe;
    if (ch) rx_data1 = ~d; else rx_data0 = ~d;
  endtask
endmodule // serial_line_model

// ---- verification/test_serial_ctrl_vector_status.sv ----
// Self-checking bench: vector codes, receive errors, data ports.
// Far side is serial_line_model; the checker is bound to the core.
`timescale 1ns/1ps
`include "serial_defs.vh"
module test_serial_ctrl_vector_status;
  reg mclk, rst_n, host_wr, host_rd;
  reg [23:0] host_addr;
  reg [7:0] host_wdata, base, rd_val, txb, d;
  reg [1:0] line_break, cts, dcd;
  wire [1:0] tx_valid, tx_ready, rx_valid, rx_parity_err, rx_framing_err;
  wire [7:0] host_rdata, tx_data0, tx_data1, rx_data0, rx_data1;
  wire [7:0] int_vector;
  wire int_req;
  integer mismatches, tests_run, sav;
  logic [7:0] rxq[2][$];
  serial_ctrl_vector_status dut (.mclk(mclk), .rst_n(rst_n),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata),
    .rx_valid(rx_valid), .rx_data0(rx_data0), .rx_data1(rx_data1),
    .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err),
    .line_break(line_break), .cts(cts), .dcd(dcd), .tx_valid(tx_valid),
    .tx_data0(tx_data0), .tx_data1(tx_data1), .tx_ready(tx_ready),
    .int_req(int_req), .int_vector(int_vector));
  serial_line_model line (.mclk(mclk), .tx_valid(tx_valid),
    .tx_data0(tx_data0), .tx_data1(tx_data1), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data0(rx_data0), .rx_data1(rx_data1),
    .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err));
  // ==========
  // Verdict, comparison and host port tasks
  task wrap_up;
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input [7:0] got, input [7:0] want);
    tests_run = tests_run + 1;
    if (got !== want) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  function [23:0] ca(input integer ch);
    ca = `CH0_CTRL_ADDR + (ch ? `CH_STRIDE : 24'h0);
  endfunction
  function [23:0] da(input integer ch);
    da = `CH0_DATA_ADDR + (ch ? `CH_STRIDE : 24'h0);
  endfunction
  // Model vector: base, code in bits 3-1 only when enabled
  function [7:0] vec(input integer ch, input integer src);
    vec = base;
    if (sav) vec[3:1] = {ch == 0, src[1:0]};
  endfunction
  task wr(input [23:0] a, input [7:0] v);
    @(negedge mclk);
    host_addr = a;
    host_wdata = v;
    host_wr = 1'b1;
    @(negedge mclk);
    host_wr = 1'b0;
  endtask
  // Read data holds, so sampling a cycle late is safe
  task rd(input [23:0] a);
    @(negedge mclk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge mclk);
    host_rd = 1'b0;
    @(negedge mclk);
    rd_val = host_rdata;
  endtask
  task wreg(input integer ch, input [2:0] r, input [7:0] v);
    wr(ca(ch), {5'h0, r});
    wr(ca(ch), v);
  endtask
  task wait_irq(input lvl);
    integer n;
    n = 0;
    while (int_req !== lvl && n < 300) begin
      @(negedge mclk);
      n = n + 1;
    end
    if (int_req !== lvl) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: interrupt wait ran out", $time);
      wrap_up;
    end
  endtask
  // ==========
  // Raise one source, check its vector, then clear it
  task raise(input integer ch, input integer src);
    d = $urandom;
    if (src == 0) begin
      rd(ca(ch));
      check(rd_val & 8'h04, 8'h04);
      txb = d;
      wr(da(ch), txb);
    end else if (src == 1) begin
      @(negedge mclk);
      if (sav) cts[ch] = ~cts[ch];
      else dcd[ch] = ~dcd[ch];
    end else begin
      rxq[ch].push_back(d);
      line.send(ch, d, 1'b0, src == 3);
    end
    wait_irq(1'b1);
    @(negedge mclk);
    check(int_vector, vec(ch, src));
    if (src == 0) check(line.got[ch].pop_front(), txb);
    if (src >= 2) begin
      if (src == 3) wr(ca(ch), 8'h30);
      rd(da(ch));
      check(rd_val, rxq[ch].pop_front());
    end else wr(ca(ch), src ? 8'h10 : 8'h28);
    wait_irq(1'b0);
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    mismatches = 0;
    tests_run = 0;
    rst_n = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 24'h0;
    host_wdata = 8'h00;
    line_break = 2'h0;
    cts = 2'h0;
    dcd = 2'h0;
    void'($urandom(12));
    base = {4'h4 + 4'($urandom_range(11)), 3'h0, 1'($urandom)};
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    for (int ch = 0; ch < 2; ch++) begin
      wr(ca(ch), 8'h18);
      wreg(ch, `WR_PARITY, 8'h01);
      wreg(ch, `WR_INT_CTRL, 8'h13);
    end
    wreg(1, `WR_VECTOR, base);
    // Vector mode on, then off; the enable lives in channel 1 only
    for (sav = 1; sav >= 0; sav--) begin
      wreg(1, `WR_INT_CTRL, sav ? 8'h17 : 8'h13);
      for (int ch = 0; ch < 2; ch++)
        for (int s = 0; s < 4; s++) raise(ch, s);
    end
    // Parity error then overrun: fourth character dropped
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      if (i < 3) rxq[0].push_back(d);
      line.send(0, d, i == 0, 1'b0);
    end
    for (int i = 0; i < 3; i++) begin
      if (i == 2) wr(ca(0), 8'h30);
      wr(ca(0), {5'h0, `RR_STATUS1});
      rd(ca(0));
      check(rd_val & 8'h70, i < 2 ? 8'h30 : 8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      rd(ca(0));
      check(rd_val & 8'h01, i < 3);
      if (i < 3) rd(da(0));
      if (i < 3) check(rd_val, rxq[0].pop_front());
    end
    // Break latches bit 7; reset-ext repeated until it reads clear
    @(negedge mclk);
    line_break[0] = 1'b1;
    wait_irq(1'b1);
    @(negedge mclk);
    check(int_vector, base);
    wr(ca(1), {5'h0, `RR_VECTOR});
    rd(ca(1));
    check(rd_val, base);
    wr(ca(0), 8'h10);
    rd(ca(0));
    check(rd_val & 8'h80, 8'h80);
    line_break[0] = 1'b0;
    for (int i = 0; i < 8 && rd_val[7]; i++) begin
      wr(ca(0), 8'h10);
      rd(ca(0));
    end
    check(rd_val & 8'h80, 8'h00);
    wr(ca(0), 8'h10);
    wait_irq(1'b0);
    wr(24'hc21009, 8'hff);
    rd(24'hc21009);
    check(rd_val, 8'h00);
    wrap_up;
  end
endmodule // test_serial_ctrl_vector_status
